//--- fstg_pkg.sv
// package: constants and types of the fm stereo test generator
package fstg_pkg;
  // ==========================================================
  // register map (word addresses on the plain port)
  localparam logic [3:0] FSTG_ADDR_CAL_FREQ = 4'h0;
  localparam logic [3:0] FSTG_ADDR_RX_FREQ = 4'h1;
  localparam logic [3:0] FSTG_ADDR_LEVEL = 4'h2;
  localparam logic [3:0] FSTG_ADDR_DEV = 4'h3;
  localparam logic [3:0] FSTG_ADDR_FREQ_L = 4'h4;
  localparam logic [3:0] FSTG_ADDR_FREQ_R = 4'h5;
  localparam logic [3:0] FSTG_ADDR_DIALOG = 4'h6;
  localparam logic [3:0] FSTG_ADDR_STATUS = 4'h7;
  localparam logic [3:0] FSTG_ADDR_CARRIER = 4'h8;
  // ==========================================================
  // field positions and values
  localparam int FSTG_STAT_EN_BIT = 0;
  localparam int FSTG_STAT_STEREO_BIT = 1;
  localparam int FSTG_STAT_QUAD_BIT = 2;
  localparam logic [15:0] FSTG_CAL_MAGIC = 16'h03E7;
  localparam logic [6:0] FSTG_LEVEL_MAX = 7'h64;
  localparam logic [6:0] FSTG_LEVEL_MONO = 7'h01;
  localparam logic [15:0] FSTG_TONE_FINE_MAX = 16'h03E8;
  localparam logic [15:0] FSTG_TONE_MAX = 16'h3A98;
  localparam logic [15:0] FSTG_TONE_FINE_STEP = 16'h000A;
  localparam logic [15:0] FSTG_TONE_COARSE_STEP = 16'h0064;
  // reset values
  localparam logic [15:0] FSTG_RST_CAL = 16'h0000;
  localparam logic [31:0] FSTG_RST_FREQ = 32'h0000_0000;
  localparam logic [6:0] FSTG_RST_LEVEL = 7'h00;
  localparam logic [15:0] FSTG_RST_DEV = 16'h0000;
  localparam logic [15:0] FSTG_RST_TONE = 16'h0000;
  // ==========================================================
  // modulation shares, in 1/1024 of full deviation (scaled *1024/100)
  localparam logic [10:0] FSTG_SHARE_TONE_ST = 11'h0E6; // 22.5 %
  localparam logic [10:0] FSTG_SHARE_TONE_MONO = 11'h200; // 50 %
  localparam logic [10:0] FSTG_SHARE_PILOT = 11'h066; // 10 %
  localparam logic [10:0] FSTG_SHARE_SIDE = 11'h0E6; // 22.5 % each sideband
  // ==========================================================
  // timing: sample clock 100 MHz, frequencies in hz; tuning word = f * 2^32 / fs
  localparam longint FSTG_CLK_HZ = 100000000;
  localparam longint FSTG_PILOT_HZ = 19000;
  localparam logic [31:0] FSTG_PILOT_TW = 32'((FSTG_PILOT_HZ * 64'h1_0000_0000) / FSTG_CLK_HZ);
  // tuning word of 1 hz with fraction bits: a whole-number step would be 2 % off
  localparam int FSTG_HZ_TW_SHIFT = 16;
  localparam logic [31:0] FSTG_HZ_TW = 32'(((64'h1_0000_0000 << FSTG_HZ_TW_SHIFT) + (FSTG_CLK_HZ / 2)) / FSTG_CLK_HZ);
  localparam logic [31:0] FSTG_QUARTER = 32'h4000_0000;
  localparam int FSTG_DW = 18;
  typedef logic signed [FSTG_DW-1:0] fstg_smp_t;
endpackage

//--- fstg_nco.sv
// one phase-accumulator oscillator with parabolic sine approximation
module fstg_nco import fstg_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [31:0] tw,
  input wire logic [31:0] ph_ofs,
  output fstg_smp_t sin_o,
  output logic [31:0] phase_o
);
  logic [31:0] acc_r;
  logic [31:0] ph;
  assign ph = acc_r + ph_ofs;
  assign phase_o = acc_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) acc_r <= 32'h0000_0000;
    else acc_r <= acc_r + tw;
  end
  // parabolic sine from the top phase bits, registered output
  // quarter wave x*(2-x) peaks at 2^16, so the sign bit is never reached
  logic [17:0] x;
  logic [35:0] sq;
  logic signed [18:0] mag;
  always_comb begin
    x = ph[30] ? ~ph[30:13] : ph[30:13];
    sq = x * x;
    mag = $signed({2'b00, x[16:0]}) - $signed({1'b0, sq[35:18]});
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sin_o <= '0;
    else sin_o <= ph[31] ? -fstg_smp_t'(mag[17:0]) : fstg_smp_t'(mag[17:0]);
  end
endmodule // fstg_nco

//--- fstg_top.sv
// top: fm stereo test generator with register port and sample mux
// Notes on behaviour
// - magic 999 calibration value enables generator
// - enabled generator replaces converter samples
// - latch receive frequency as carrier on activation
// - carrier ignores receive changes while dialog closed
// - reopening dialog reloads carrier frequency
// - output amplitude scaled by level 0..100
// - stereo encoder only when level above one
// - tones and stereo signals frequency modulate carrier
// - tone modulates only when frequency nonzero
// - tone steps 10 hz, then 100 hz
// - equal tones run ninety degrees apart
// - tone share 22.5 stereo, 50 mono
// - pilot 10, each sideband 22.5 percent
// - datapaths at least eighteen bits
//
// Decided for this implementation: the strobed register port and the register offsets.
module fstg_top import fstg_pkg::*; (
  // clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // register port
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // sample stream
  input wire logic signed [17:0] ADC_DATA,
  output logic signed [17:0] DSP_DATA,
  output logic GEN_ACTIVE
);
  // ==========================================================
  // reset release
  // two stages so the internal reset leaves on a clean edge
  logic rs1_r;
  logic rst_n;
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rs1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1_r <= 1'b1;
      rst_n <= rs1_r;
    end
  end
  // ==========================================================
  // write strobes
  logic wr_cal;
  logic wr_rx;
  logic wr_level;
  logic wr_dev;
  logic wr_tone_l;
  logic wr_tone_r;
  logic wr_dialog;
  assign wr_cal = WR && (ADDR == FSTG_ADDR_CAL_FREQ);
  assign wr_rx = WR && (ADDR == FSTG_ADDR_RX_FREQ);
  assign wr_level = WR && (ADDR == FSTG_ADDR_LEVEL);
  assign wr_dev = WR && (ADDR == FSTG_ADDR_DEV);
  assign wr_tone_l = WR && (ADDR == FSTG_ADDR_FREQ_L);
  assign wr_tone_r = WR && (ADDR == FSTG_ADDR_FREQ_R);
  assign wr_dialog = WR && (ADDR == FSTG_ADDR_DIALOG);
  // ==========================================================
  // settings, one register per concern
  logic [15:0] cal_r;
  logic [15:0] dev_r;
  logic [15:0] freq_l_r;
  logic [15:0] freq_r_r;
  logic [31:0] rx_freq_r;
  logic [31:0] carrier_r;
  logic [6:0] level_r;
  logic dialog_r;
  logic enabled;
  // snaps a tone request onto the 10 hz / 100 hz grid, saturating at the top
  function automatic logic [15:0] snap_tone(input logic [31:0] f);
    logic [15:0] c;
    c = (f > 32'(FSTG_TONE_MAX)) ? FSTG_TONE_MAX : f[15:0];
    if (c <= FSTG_TONE_FINE_MAX) snap_tone = c - (c % FSTG_TONE_FINE_STEP);
    else snap_tone = c - (c % FSTG_TONE_COARSE_STEP);
  endfunction
  // upper bits set can never be the magic value, so they park the register at zero
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      cal_r <= FSTG_RST_CAL;
    end else if (wr_cal) begin
      cal_r <= (WDATA[31:16] != 16'h0000) ? FSTG_RST_CAL : WDATA[15:0];
    end
  end
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      rx_freq_r <= FSTG_RST_FREQ;
    end else if (wr_rx) begin
      rx_freq_r <= WDATA;
    end
  end
  // clamp on the whole word: a large write must not wrap into range
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      level_r <= FSTG_RST_LEVEL;
    end else if (wr_level) begin
      level_r <= (WDATA > 32'(FSTG_LEVEL_MAX)) ? FSTG_LEVEL_MAX : WDATA[6:0];
    end
  end
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      dev_r <= FSTG_RST_DEV;
    end else if (wr_dev) begin
      dev_r <= WDATA[15:0];
    end
  end
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      freq_l_r <= FSTG_RST_TONE;
    end else if (wr_tone_l) begin
      freq_l_r <= snap_tone(WDATA);
    end
  end
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      freq_r_r <= FSTG_RST_TONE;
    end else if (wr_tone_r) begin
      freq_r_r <= snap_tone(WDATA);
    end
  end
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      dialog_r <= 1'b0;
    end else if (wr_dialog) begin
      dialog_r <= WDATA[0];
    end
  end
  assign enabled = (cal_r == FSTG_CAL_MAGIC);
  // ==========================================================
  // carrier latch
  // loads on activation and on each dialog opening only, so a closed dialog freezes it
  logic en_d_r;
  logic dlg_d_r;
  logic carrier_load;
  assign carrier_load = (enabled && !en_d_r) || (dialog_r && !dlg_d_r);
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      en_d_r <= 1'b0;
      dlg_d_r <= 1'b0;
    end else begin
      en_d_r <= enabled;
      dlg_d_r <= dialog_r;
    end
  end
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) carrier_r <= FSTG_RST_FREQ;
    else if (carrier_load) carrier_r <= rx_freq_r;
    // closed dialog: carrier holds, generator stays on
    else carrier_r <= carrier_r;
  end
  // ==========================================================
  // tone oscillators
  logic stereo;
  logic quad;
  logic tone_l_on;
  logic tone_r_on;
  logic [2:0] status;
  assign stereo = level_r > FSTG_LEVEL_MONO;
  assign quad = (freq_l_r == freq_r_r);
  assign tone_l_on = freq_l_r != 16'h0000;
  assign tone_r_on = freq_r_r != 16'h0000;
  assign status = {quad, stereo, enabled};
  // tuning words carry fraction bits so the frequency error stays far below 1 hz
  logic [31:0] tw_l;
  logic [31:0] tw_r;
  logic [31:0] tw_sc;
  assign tw_l = 32'((64'(freq_l_r) * 64'(FSTG_HZ_TW)) >> FSTG_HZ_TW_SHIFT);
  assign tw_r = 32'((64'(freq_r_r) * 64'(FSTG_HZ_TW)) >> FSTG_HZ_TW_SHIFT);
  fstg_smp_t s_l;
  fstg_smp_t s_r;
  fstg_smp_t s_p;
  fstg_smp_t s_sc;
  // right tone in quadrature shares the left tuning word, so the 90 degree offset is exact
  fstg_smp_t s_rq;
  fstg_nco u_l (
    .clk(CLK),
    .rst_n(rst_n),
    .tw(tw_l),
    .ph_ofs(32'h0000_0000),
    .sin_o(s_l),
    .phase_o()
  );
  fstg_nco u_r (
    .clk(CLK),
    .rst_n(rst_n),
    .tw(tw_r),
    .ph_ofs(32'h0000_0000),
    .sin_o(s_r),
    .phase_o()
  );
  fstg_nco u_q (
    .clk(CLK),
    .rst_n(rst_n),
    .tw(tw_l),
    .ph_ofs(FSTG_QUARTER),
    .sin_o(s_rq),
    .phase_o()
  );
  // ==========================================================
  // pilot and subcarrier
  // subcarrier at twice the pilot rate: both accumulators start at zero, so it stays locked
  assign tw_sc = {FSTG_PILOT_TW[30:0], 1'b0};
  fstg_nco u_p (
    .clk(CLK),
    .rst_n(rst_n),
    .tw(FSTG_PILOT_TW),
    .ph_ofs(32'h0000_0000),
    .sin_o(s_p),
    .phase_o()
  );
  fstg_nco u_s (
    .clk(CLK),
    .rst_n(rst_n),
    .tw(tw_sc),
    .ph_ofs(32'h0000_0000),
    .sin_o(s_sc),
    .phase_o()
  );
  // ==========================================================
  // stereo multiplex, shares in 1/1024 of full deviation
  logic signed [17:0] l_s;
  logic signed [17:0] r_s;
  logic signed [18:0] diff;
  logic signed [36:0] dsb;
  logic [10:0] tone_share;
  logic signed [29:0] tone_part;
  logic signed [29:0] pilot_part;
  logic signed [29:0] side_part;
  logic signed [29:0] mpx;
  always_comb begin
    l_s = tone_l_on ? s_l : 18'sh0;
    r_s = tone_r_on ? (quad ? s_rq : s_r) : 18'sh0;
    diff = 19'(l_s) - 19'(r_s);
    dsb = diff * s_sc;
    tone_share = stereo ? FSTG_SHARE_TONE_ST : FSTG_SHARE_TONE_MONO;
    tone_part = 30'(l_s * $signed({1'b0, tone_share})) + 30'(r_s * $signed({1'b0, tone_share}));
    // both sidebands of the suppressed subcarrier, hence twice the single share
    side_part = 30'($signed(dsb[35:18]) * $signed({1'b0, FSTG_SHARE_SIDE}) * 2);
    pilot_part = 30'(s_p * $signed({1'b0, FSTG_SHARE_PILOT}));
    // mono: no pilot and no difference signal at all
    if (stereo) mpx = tone_part + pilot_part + side_part;
    else mpx = tone_part;
  end
  // ==========================================================
  // fm carrier: deviation in hz per full-scale mpx
  logic signed [47:0] dev_hz;
  logic [31:0] tw_carrier;
  logic [31:0] tw_dev;
  logic [31:0] tw_c;
  always_comb begin
    dev_hz = (48'(mpx) * $signed({1'b0, dev_r})) >>> 27;
    tw_carrier = 32'((64'(carrier_r) * 64'(FSTG_HZ_TW)) >> FSTG_HZ_TW_SHIFT);
    tw_dev = 32'((dev_hz * $signed({1'b0, FSTG_HZ_TW})) >>> FSTG_HZ_TW_SHIFT);
    tw_c = tw_carrier + tw_dev;
  end
  fstg_smp_t s_c;
  fstg_nco u_c (
    .clk(CLK),
    .rst_n(rst_n),
    .tw(tw_c),
    .ph_ofs(32'h0000_0000),
    .sin_o(s_c),
    .phase_o()
  );
  // ==========================================================
  // level scaling and sample mux, 18-bit datapath
  logic signed [25:0] scaled;
  logic signed [17:0] dsp_nxt;
  assign scaled = s_c * $signed({1'b0, level_r});
  // divide by 100 keeps the level in plain percent; the sine peak leaves headroom for it
  assign dsp_nxt = enabled ? 18'(scaled / 26'sd100) : ADC_DATA;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) DSP_DATA <= '0;
    else DSP_DATA <= dsp_nxt;
  end
  assign GEN_ACTIVE = enabled;
  // ==========================================================
  // read port: data stands one cycle after the strobe, zero otherwise
  logic [31:0] rdata_nxt;
  always_comb begin
    case (ADDR)
      FSTG_ADDR_CAL_FREQ: rdata_nxt = {16'h0000, cal_r};
      FSTG_ADDR_RX_FREQ: rdata_nxt = rx_freq_r;
      FSTG_ADDR_LEVEL: rdata_nxt = {25'h0, level_r};
      FSTG_ADDR_DEV: rdata_nxt = {16'h0000, dev_r};
      FSTG_ADDR_FREQ_L: rdata_nxt = {16'h0000, freq_l_r};
      FSTG_ADDR_FREQ_R: rdata_nxt = {16'h0000, freq_r_r};
      FSTG_ADDR_DIALOG: rdata_nxt = {31'h0, dialog_r};
      FSTG_ADDR_STATUS: rdata_nxt = {29'h0, status};
      FSTG_ADDR_CARRIER: rdata_nxt = carrier_r;
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) RDATA <= 32'h0000_0000;
    else if (RD) RDATA <= rdata_nxt;
    else RDATA <= 32'h0000_0000;
  end
endmodule // fstg_top

//--- fstg_chk_asserts.sv
// checker: port-level assertions of the fm stereo test generator
module fstg_chk import fstg_pkg::*; (
  // clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // register port
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  // sample stream
  input wire logic signed [17:0] ADC_DATA,
  input wire logic signed [17:0] DSP_DATA,
  input wire logic GEN_ACTIVE
);
  logic [31:0] rx_r;
  logic cal_wr;
  assign cal_wr = WR && ADDR == FSTG_ADDR_CAL_FREQ;
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rx_r <= 32'h0;
    end else if (WR && ADDR == FSTG_ADDR_RX_FREQ) begin
      rx_r <= WDATA;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  gen_on_a: assert property (cal_wr && WDATA == 32'(FSTG_CAL_MAGIC) |=> GEN_ACTIVE)
    else $error("generator not enabled by magic value");
  gen_off_a: assert property (cal_wr && WDATA != 32'(FSTG_CAL_MAGIC) |=> !GEN_ACTIVE)
    else $error("generator enabled by other value");
  gen_hold_a: assert property (GEN_ACTIVE && !cal_wr |=> GEN_ACTIVE)
    else $error("generator dropped without write");
  adc_pass_a: assert property (!GEN_ACTIVE && !$past(GEN_ACTIVE) |-> DSP_DATA == $past(ADC_DATA))
    else $error("bypass sample wrong");
  rd_idle_a: assert property (!$past(RD) |-> RDATA == 32'h0)
    else $error("read data outside read slot");
  en_stat_a: assert property (RD && ADDR == FSTG_ADDR_STATUS |=> RDATA[0] == $past(GEN_ACTIVE))
    else $error("status enable bit wrong");
  rx_back_a: assert property (RD && ADDR == FSTG_ADDR_RX_FREQ |=> RDATA == $past(rx_r))
    else $error("receive frequency readback wrong");
  lvl_max_a: assert property (RD && ADDR == FSTG_ADDR_LEVEL |=> RDATA <= 32'h64)
    else $error("level above full scale");
  tone_max_a: assert property (RD && ADDR == FSTG_ADDR_FREQ_L |=> RDATA <= 32'h3A98)
    else $error("tone above maximum");
endmodule // fstg_chk
bind fstg_top fstg_chk u_chk (.CLK(CLK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .ADC_DATA(ADC_DATA), .DSP_DATA(DSP_DATA), .GEN_ACTIVE(GEN_ACTIVE));

//--- fstg_sink.sv
// partner: processing chain input that counts non-zero samples
module fstg_sink (
  input wire logic clk,
  input wire logic clr,
  input wire logic signed [17:0] smp,
  output int nz_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk) begin
    if (clr) begin
      nz_cnt <= 0;
    end else if (smp != 18'sh0) begin
      nz_cnt <= nz_cnt + 1;
    end
  end
endmodule // fstg_sink

//--- tb.sv
// testbench: fm stereo test generator
module tb import fstg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 0, ARST_N = 0, WR = 0, RD = 0, clr = 1;
  logic [3:0] ADDR = 4'h0;
  logic [31:0] WDATA = 32'h0, RDATA, d;
  logic signed [17:0] ADC_DATA = 18'sh0, DSP_DATA;
  logic GEN_ACTIVE;
  int fails = 0, check_count = 0, nz;
  fstg_top DUT (.CLK(CLK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .ADC_DATA(ADC_DATA), .DSP_DATA(DSP_DATA), .GEN_ACTIVE(GEN_ACTIVE));
  fstg_sink u_sink (.clk(CLK), .clr(clr), .smp(DSP_DATA), .nz_cnt(nz));
  initial forever #5 CLK = ~CLK;
  // ==========================================================
  // bus tasks and compare
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge CLK);
    ADDR <= a; WDATA <= v; WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    @(posedge CLK);
    ADDR <= a; RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 chk(RDATA, e);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_bypass();
    rdc(FSTG_ADDR_STATUS, 32'h4);
    rdc(4'hF, 32'h0);
    @(posedge CLK) ADC_DATA <= 18'sh1234;
    repeat (2) @(posedge CLK);
    #1 chk(32'(DSP_DATA), 32'(18'sh1234));
  endtask
  task automatic t_latch();
    wr(FSTG_ADDR_DIALOG, 32'h1);
    wr(FSTG_ADDR_RX_FREQ, 32'h000F_4240);
    wr(FSTG_ADDR_CAL_FREQ, 32'(FSTG_CAL_MAGIC));
    #1 chk(32'(GEN_ACTIVE), 32'h1);
    rdc(FSTG_ADDR_CARRIER, 32'h000F_4240);
    wr(FSTG_ADDR_DIALOG, 32'h0);
    wr(FSTG_ADDR_RX_FREQ, 32'h001E_8480);
    rdc(FSTG_ADDR_CARRIER, 32'h000F_4240);
    #1 chk(32'(GEN_ACTIVE), 32'h1);
    wr(FSTG_ADDR_DIALOG, 32'h1);
    rdc(FSTG_ADDR_CARRIER, 32'h001E_8480);
  endtask
  task automatic t_level();
    repeat (10) @(posedge CLK);
    #1 chk(32'(DSP_DATA), 32'h0);
    wr(FSTG_ADDR_LEVEL, 32'h1);
    rdc(FSTG_ADDR_STATUS, 32'h5);
    wr(FSTG_ADDR_LEVEL, 32'hC8);
    rdc(FSTG_ADDR_LEVEL, 32'h64);
    rdc(FSTG_ADDR_STATUS, 32'h7);
  endtask
  task automatic t_tones();
    wr(FSTG_ADDR_DEV, 32'h0001_24F8);
    wr(FSTG_ADDR_FREQ_L, 32'h4D2);
    rdc(FSTG_ADDR_FREQ_L, 32'h4B0);
    wr(FSTG_ADDR_FREQ_R, 32'h7B);
    rdc(FSTG_ADDR_FREQ_R, 32'h78);
    wr(FSTG_ADDR_FREQ_L, 32'h4E20);
    rdc(FSTG_ADDR_FREQ_L, 32'h3A98);
    wr(FSTG_ADDR_FREQ_R, 32'h3A98);
    rdc(FSTG_ADDR_STATUS, 32'h7);
    @(posedge CLK);
    // silent converter: every non-zero sample must come from the generator
    ADC_DATA <= 18'sh0;
    clr <= 1'b0;
    repeat (200) @(posedge CLK);
    chk(32'(nz > 0), 32'h1);
    wr(FSTG_ADDR_CAL_FREQ, 32'h3E6);
    #1 chk(32'(GEN_ACTIVE), 32'h0);
  endtask
  initial begin
    repeat (3) @(posedge CLK);
    ARST_N <= 1'b1;
    repeat (4) @(posedge CLK);
    t_bypass();
    t_latch();
    t_level();
    t_tones();
    tally_and_finish();
  end
  initial begin
    #100us fails++;
    tally_and_finish();
  end
endmodule // tb
